// ---- bench/pbsp_host.sv ----
// processor-side model that drives the port pins
`timescale 1ns/1ps
module pbsp_host (
	// clock
	input wire logic i_mclk,
	// pins toward the port
	output pbsp_pkg::pbsp_addr_type o_addr,
	output logic o_proc_strobe_n,
	output logic o_ctrl_strobe_n,
	output logic o_advance_n,
	output logic [2:0] o_sel,
	output pbsp_pkg::pbsp_wr_ctrl_type o_wr_ctrl,
	output pbsp_pkg::pbsp_word_type o_word,
	output logic o_burst_order
);
	import pbsp_pkg::*;
	// *****
	// bus cycles
	// *****
	initial begin
		{o_proc_strobe_n, o_ctrl_strobe_n, o_advance_n} = 3'h7;
		o_addr = '0;
		o_sel = 3'h2;
		o_wr_ctrl = 6'h3F;
		o_word = '0;
		o_burst_order = 1'b0;
	end
	// strap moves only while the port is held in reset
	task automatic strap(input logic v);
		o_burst_order = v;
	endtask
	// set just after an edge, held through the next one
	task automatic step(input logic ps_n, cs_n, fwd_n,
		input logic [2:0] sel, input pbsp_wr_ctrl_type wc,
		input pbsp_addr_type a, input pbsp_word_type d);
		@(posedge i_mclk);
		#1;
		o_proc_strobe_n = ps_n;
		o_ctrl_strobe_n = cs_n;
		o_advance_n = fwd_n;
		o_sel = sel;
		o_wr_ctrl = wc;
		o_addr = a;
		o_word = d;
	endtask
endmodule

// ---- bench/pbsp_top_test.sv ----
// self-checking bench for the pipelined burst sram port
`timescale 1ns/1ps
module pbsp_top_test;
	import pbsp_pkg::*;
	// *****
	// signals and instances
	// *****
	localparam pbsp_wr_ctrl_type RD = 6'h3F;
	localparam pbsp_wr_ctrl_type FULL = 6'h1F;
	localparam pbsp_wr_ctrl_type LANES_02 = 6'h2A;
	localparam pbsp_wr_ctrl_type NO_EN = 6'h30;
	localparam logic [2:0] SEL = 3'h2;
	localparam pbsp_addr_type BASE = 17'h1ABC0;
	localparam pbsp_addr_type FAR = 17'h00010;
	logic i_mclk, i_rst_n, oe_n, sleep, order, ps_n, cs_n, fwd_n, oe;
	logic [2:0] sel;
	logic [31:0] dq;
	logic [3:0] par;
	pbsp_addr_type addr;
	pbsp_wr_ctrl_type wc;
	pbsp_word_type hw, o_w, ref_mem [4];
	int miscompares, check_count;
	assign o_w = {par, dq};
	pbsp_host pbsp_host_i (.i_mclk(i_mclk), .o_addr(addr),
		.o_proc_strobe_n(ps_n), .o_ctrl_strobe_n(cs_n),
		.o_advance_n(fwd_n), .o_sel(sel), .o_wr_ctrl(wc), .o_word(hw),
		.o_burst_order(order));
	pbsp_top pbsp_top_i (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
		.i_addr(addr), .i_proc_addr_strobe_n(ps_n),
		.i_ctrl_addr_strobe_n(cs_n), .i_burst_advance_n(fwd_n),
		.i_chip_sel_one_n(sel[2]), .i_chip_sel_two(sel[1]),
		.i_chip_sel_three_n(sel[0]), .i_wr_ctrl(wc),
		.i_output_enable_n(oe_n), .i_sleep_request(sleep),
		.i_burst_order(order), .i_dq(oe ? dq : hw.data),
		.i_parity_io(oe ? par : hw.parity), .o_dq(dq),
		.o_parity_io(par), .o_dq_oe(oe));
	initial begin
		i_mclk = 1'b0;
		forever #2.5 i_mclk = ~i_mclk;
	end
	// *****
	// checking and closing
	// *****
	task automatic cmp_word(input string what, input pbsp_word_type e, g);
		check_count++;
		if (g !== e) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", what, e, g);
		end
	endtask
	task automatic cmp_bit(input string what, input logic e, g);
		check_count++;
		if (g !== e) begin
			miscompares++;
			$display("ERROR %s expected %b seen %b", what, e, g);
		end
	endtask
	task automatic test_done;
		$display("checks %0d miscompares %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	initial begin
		#20000;
		miscompares++;
		test_done;
	end
	// *****
	// scenarios
	// *****
	task automatic do_reset(input logic v);
		i_rst_n = 1'b0;
		pbsp_host_i.strap(v);
		repeat (8) @(posedge i_mclk);
		#1;
		i_rst_n = 1'b1;
	endtask
	task automatic desel;
		pbsp_host_i.step('1,'0,'1,3'h6,RD,'0,'0);
		pbsp_host_i.step('1,'1,'1,SEL,RD,'0,'0);
		cmp_bit("deselect drive", '0, oe);
	endtask
	task automatic t_fill;
		for (int i = 0; i < 4; i++) begin
			ref_mem[i] = {4'(i + 5), 32'(32'hC0DE0000 + i)};
			pbsp_host_i.step('1,'0,'1,SEL,FULL,BASE+17'(i),ref_mem[i]);
		end
		pbsp_host_i.step('1,'0,'1,SEL,FULL,FAR,'1);
	endtask
	task automatic t_burst(input logic ord, input logic [1:0] s);
		logic [1:0] lo [4];
		for (int k = 0; k < 4; k++)
			lo[k] = ord ? s ^ 2'(k) : s + 2'(k);
		pbsp_host_i.step('0,'1,'1,SEL,RD,BASE+17'(s),'0);
		for (int k = 1; k < 7; k++) begin
			pbsp_host_i.step('1,'1,k > 3,SEL,RD,'0,'0);
			if (k == 1)
				cmp_bit("first read drive", '0, oe);
			else
				cmp_word("burst", ref_mem[lo[k > 5 ? 3 : k - 2]], o_w);
		end
		cmp_bit("read drive", '1, oe);
	endtask
	task automatic t_async;
		pbsp_host_i.step('0,'1,'1,SEL,RD,BASE,'0);
		pbsp_host_i.step('0,'1,'1,3'h6,RD,FAR,'0);
		pbsp_host_i.step('1,'1,'1,SEL,RD,'0,'0);
		pbsp_host_i.step('1,'1,'1,SEL,RD,'0,'0);
		cmp_word("gated strobe", ref_mem[0], o_w);
		cmp_bit("gated strobe drive", '1, oe);
		oe_n = 1'b1;
		#1;
		cmp_bit("drive off", '0, oe);
		@(posedge i_mclk);
		#1;
		oe_n = 1'b0;
		sleep = 1'b1;
		#1;
		cmp_bit("sleep drive", '0, oe);
		pbsp_host_i.step('0,'1,'1,SEL,RD,FAR,'0);
		pbsp_host_i.step('1,'1,'1,SEL,RD,'0,'0);
		sleep = 1'b0;
		pbsp_host_i.step('1,'1,'1,SEL,RD,'0,'0);
		pbsp_host_i.step('1,'1,'1,SEL,RD,'0,'0);
		cmp_word("sleep hold", ref_mem[0], o_w);
	endtask
	task automatic t_bytes;
		pbsp_word_type nw;
		nw = {4'h5, 32'h12345678};
		for (int n = 0; n < 4; n += 2) begin
			ref_mem[3].data[8*n+:8] = nw.data[8*n+:8];
			ref_mem[3].parity[n] = nw.parity[n];
		end
		pbsp_host_i.step('1,'0,'1,SEL,LANES_02,BASE+17'h3,nw);
		pbsp_host_i.step('1,'0,'1,SEL,NO_EN,BASE+17'h3,'0);
		pbsp_host_i.step('1,'1,'1,SEL,RD,'0,'0);
		pbsp_host_i.step('1,'1,'1,SEL,RD,'0,'0);
		cmp_word("lane write", ref_mem[3], o_w);
	endtask
	task automatic t_bad;
		logic [2:0] bad [3] = '{3'h0, 3'h3, 3'h6};
		foreach (bad[j])
			pbsp_host_i.step('1,'0,'1,bad[j],FULL,BASE,'0);
		pbsp_host_i.step('0,'0,'1,SEL,FULL,BASE+17'h1,'0);
		cmp_bit("bad select drive", '0, oe);
		pbsp_host_i.step('1,'1,'1,SEL,RD,'0,'0);
		pbsp_host_i.step('1,'1,'1,SEL,RD,'0,'0);
		cmp_word("both strobes", ref_mem[1], o_w);
	endtask
	task automatic t_pwrite;
		pbsp_word_type old;
		old = ref_mem[2];
		ref_mem[2] = {4'h3, 32'hFACE0002};
		pbsp_host_i.step('0,'1,'1,SEL,FULL,BASE+17'h2,'1);
		pbsp_host_i.step('1,'1,'1,SEL,FULL,'0,ref_mem[2]);
		pbsp_host_i.step('1,'1,'1,SEL,RD,'0,'0);
		cmp_word("first write cycle", old, o_w);
	endtask
	initial begin
		i_rst_n = 1'b0;
		oe_n = 1'b0;
		sleep = 1'b0;
		do_reset('0);
		t_fill;
		desel;
		t_burst('0, 2'h1);
		desel;
		t_async;
		desel;
		t_bytes;
		t_bad;
		desel;
		t_pwrite;
		desel;
		t_burst('0, 2'h3);
		do_reset('1);
		t_burst('1, 2'h2);
		test_done;
	end
endmodule

// ---- logic/pbsp_mem.sv ----
// lane-split storage array with registered read and write-through
`timescale 1ns/1ps
`include "pbsp_params.svh"
module pbsp_mem (
	// clock
	input wire logic i_mclk,
	// read port
	input wire pbsp_pkg::pbsp_addr_type i_rd_addr,
	output pbsp_pkg::pbsp_word_type o_rd_word,
	// write port
	input wire pbsp_pkg::pbsp_mask_type i_wr_mask,
	input wire pbsp_pkg::pbsp_addr_type i_wr_addr,
	input wire pbsp_pkg::pbsp_word_type i_wr_word
);
	import pbsp_pkg::*;

	logic [`PBSP_LANES-1:0] rd_par;
	logic [`PBSP_DATA_W-1:0] rd_dat;

	// ****************************************
	// one array per lane
	// ****************************************
	for (genvar n = 0; n < `PBSP_LANES; n++) begin : g_lane
		logic [`PBSP_LANE_W:0] lane_mem [0:`PBSP_DEPTH-1];
		logic [`PBSP_LANE_W:0] wr_lane;
		logic [`PBSP_LANE_W:0] rd_lane_r;
		// lane n gathers its data byte and its parity bit [RULE_22]
		assign wr_lane = {i_wr_word.parity[n],
			i_wr_word.data[n*`PBSP_LANE_W +: `PBSP_LANE_W]};
		always_ff @(posedge i_mclk) begin
			// unselected lanes are simply not written [RULE_20]
			if (i_wr_mask[n]) begin
				lane_mem[i_wr_addr] <= wr_lane;
			end
			// write-through covers a read of the word being written
			if (i_wr_mask[n] && (i_wr_addr == i_rd_addr)) begin
				rd_lane_r <= wr_lane;
			end else begin
				rd_lane_r <= lane_mem[i_rd_addr];
			end
		end
		assign rd_par[n] = rd_lane_r[`PBSP_LANE_W];
		assign rd_dat[n*`PBSP_LANE_W +: `PBSP_LANE_W] =
			rd_lane_r[`PBSP_LANE_W-1:0];
	end

	assign o_rd_word = {rd_par, rd_dat};

endmodule

// ---- logic/pbsp_params.svh ----
// constants for the pipelined burst sram port
// Behaviour
// RULE_01 - address captured only on a strobe with all three chip selects active
// RULE_02 - two low captured address bits seed the 2-bit burst counter
// RULE_03 - four low-active lane selects write their lanes when lane enable is low
// RULE_04 - global write low writes all four lanes, overriding the lane controls
// RULE_05 - controller drives lane enable low for a lane-selective write
// RULE_06 - burst counter steps when advance is low, otherwise holds
// RULE_07 - selected only when select one low, two high, three low
// RULE_08 - processor strobe ignored while select one is high
// RULE_09 - low output enable drives the data pins, high leaves them as inputs
// RULE_10 - first clock of a read after deselect keeps the pins undriven
// RULE_11 - processor strobe loads address register and burst counter
// RULE_12 - controller strobe loads address register and burst counter too
// RULE_13 - with both strobes low only the processor strobe is acted on
// RULE_14 - sleep high idles the port and keeps the array contents
// RULE_15 - write data and parity captured into an input register at the edge
// RULE_16 - pins show the word addressed one clock earlier
// RULE_17 - burst order strap is tied static: low linear, high interleaved
// RULE_18 - controller keeps global write and lane enable high to read
// RULE_19 - processor write ignores write controls first cycle, uses the second
// RULE_20 - unselected lanes keep their stored contents during a byte write
// RULE_21 - interleaved order xors the start bits, linear adds modulo four
// RULE_22 - lane n is data bits 8n+7..8n with parity n, select n
`ifndef PBSP_PARAMS_SVH
`define PBSP_PARAMS_SVH
`define PBSP_ADDR_W 17
`define PBSP_DATA_W 32
`define PBSP_LANES 4
`define PBSP_LANE_W 8
`define PBSP_CNT_W 2
`define PBSP_DEPTH 131072
`define PBSP_ALL_LANES 4'hF
`define PBSP_NO_LANES 4'h0
`define PBSP_CNT_ZERO 2'h0
`define PBSP_CNT_STEP 2'h1
`define PBSP_ST_IDLE 2'h1
`define PBSP_ST_BURST 2'h2
`define PBSP_WORD_ZERO 36'h0
`define PBSP_ADDR_ZERO 17'h0
`endif

// ---- logic/pbsp_pkg.sv ----
// types shared by the pipelined burst sram port
package pbsp_pkg;
`include "pbsp_params.svh"

typedef logic [`PBSP_ADDR_W-1:0] pbsp_addr_type;
typedef logic [`PBSP_LANES-1:0] pbsp_mask_type;
typedef logic [`PBSP_CNT_W-1:0] pbsp_cnt_type;

typedef struct packed {
	logic [`PBSP_LANES-1:0] parity;
	logic [`PBSP_DATA_W-1:0] data;
} pbsp_word_type;

typedef struct packed {
	logic all_lanes_write_n;
	logic lane_write_enable_n;
	logic [`PBSP_LANES-1:0] byte_lane_write_sel_n;
} pbsp_wr_ctrl_type;

typedef enum logic [1:0] {
	PBSP_IDLE = `PBSP_ST_IDLE,
	PBSP_BURST = `PBSP_ST_BURST
} pbsp_state_type;

endpackage

// ---- logic/pbsp_top.sv ----
// pin-level pipelined burst sram port
`timescale 1ns/1ps
`include "pbsp_params.svh"
module pbsp_top (
	// clock and reset
	input wire logic i_mclk,
	input wire logic i_rst_n,
	// address and strobes
	input wire pbsp_pkg::pbsp_addr_type i_addr,
	input wire logic i_proc_addr_strobe_n,
	input wire logic i_ctrl_addr_strobe_n,
	input wire logic i_burst_advance_n,
	// chip selects
	input wire logic i_chip_sel_one_n,
	input wire logic i_chip_sel_two,
	input wire logic i_chip_sel_three_n,
	// write controls
	input wire pbsp_pkg::pbsp_wr_ctrl_type i_wr_ctrl,
	// asynchronous controls and strap
	input wire logic i_output_enable_n,
	input wire logic i_sleep_request,
	input wire logic i_burst_order,
	// data pins, split into in, out and enable
	input wire logic [`PBSP_DATA_W-1:0] i_dq,
	input wire logic [`PBSP_LANES-1:0] i_parity_io,
	output logic [`PBSP_DATA_W-1:0] o_dq,
	output logic [`PBSP_LANES-1:0] o_parity_io,
	output logic o_dq_oe
);
	import pbsp_pkg::*;

	// ****************************************
	// decode helpers
	// ****************************************
	function automatic pbsp_mask_type lane_mask(input pbsp_wr_ctrl_type c);
		pbsp_mask_type m;
		m = `PBSP_NO_LANES;
		if (!c.all_lanes_write_n) begin
			m = `PBSP_ALL_LANES; // [RULE_04]
		end else if (!c.lane_write_enable_n) begin
			m = ~c.byte_lane_write_sel_n; // [RULE_03] [RULE_05] [RULE_22]
		end
		return m;
	endfunction

	function automatic pbsp_cnt_type burst_low(input pbsp_cnt_type s,
		input pbsp_cnt_type c, input logic interleaved);
		pbsp_cnt_type r;
		r = s + c; // [RULE_21]
		if (interleaved) begin
			r = s ^ c; // [RULE_21]
		end
		return r;
	endfunction

	// ****************************************
	// strobe and select qualification
	// ****************************************
	logic selected;
	logic proc_seen;
	logic ctrl_seen;
	logic any_seen;
	logic start;
	logic deselect;
	pbsp_mask_type req_mask;

	assign selected = !i_chip_sel_one_n && i_chip_sel_two &&
		!i_chip_sel_three_n; // [RULE_07]
	// sleep blocks new activity but touches no stored word [RULE_14]
	assign proc_seen = !i_proc_addr_strobe_n && !i_chip_sel_one_n &&
		!i_sleep_request; // [RULE_08]
	assign ctrl_seen = !i_ctrl_addr_strobe_n && !proc_seen &&
		!i_sleep_request; // [RULE_13]
	assign any_seen = proc_seen || ctrl_seen;
	assign start = any_seen && selected; // [RULE_01]
	assign deselect = any_seen && !selected;
	assign req_mask = lane_mask(i_wr_ctrl);

	// ****************************************
	// access state
	// ****************************************
	pbsp_state_type state_r, state_nxt;
	pbsp_addr_type addr_r, addr_nxt;
	pbsp_cnt_type cnt_r, cnt_nxt;
	pbsp_addr_type acc_addr;
	pbsp_mask_type wmask_r, wmask_nxt;
	pbsp_addr_type waddr_r, waddr_nxt;
	pbsp_word_type wword_r, wword_nxt;
	logic rdv_r, rdv_nxt;
	logic outv_r, outv_nxt;
	pbsp_word_type dq_r, dq_nxt;
	pbsp_word_type mem_rd;
	logic do_write;

	always_comb begin
		state_nxt = state_r;
		addr_nxt = addr_r;
		cnt_nxt = cnt_r;
		wmask_nxt = `PBSP_NO_LANES;
		waddr_nxt = waddr_r;
		wword_nxt = wword_r;
		rdv_nxt = 1'b0;
		do_write = 1'b0;
		acc_addr = addr_r;
		// one cycle of output pipeline behind the array read [RULE_16]
		outv_nxt = rdv_r;
		dq_nxt = rdv_r ? mem_rd : dq_r;
		if (start) begin
			state_nxt = PBSP_BURST;
			addr_nxt = i_addr; // [RULE_11] [RULE_12]
			cnt_nxt = `PBSP_CNT_ZERO; // [RULE_02]
			acc_addr = i_addr;
			// a processor start is always a read first [RULE_19]
			do_write = ctrl_seen && (req_mask != `PBSP_NO_LANES);
		end else if (deselect) begin
			state_nxt = PBSP_IDLE;
			outv_nxt = 1'b0;
		end else if ((state_r == PBSP_BURST) && !i_sleep_request) begin
			if (!i_burst_advance_n) begin
				cnt_nxt = cnt_r + `PBSP_CNT_STEP; // [RULE_06]
			end
			// strap is taken as static, so no resync [RULE_17]
			acc_addr = {addr_r[`PBSP_ADDR_W-1:`PBSP_CNT_W],
				burst_low(addr_r[`PBSP_CNT_W-1:0], cnt_nxt,
				i_burst_order)}; // [RULE_02]
			do_write = (req_mask != `PBSP_NO_LANES); // [RULE_19]
		end
		if (start || ((state_r == PBSP_BURST) && !deselect &&
			!i_sleep_request)) begin
			if (do_write) begin
				wmask_nxt = req_mask;
				waddr_nxt = acc_addr;
				wword_nxt = {i_parity_io, i_dq}; // [RULE_15]
			end else begin
				rdv_nxt = 1'b1; // [RULE_18]
			end
		end
	end

	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			state_r <= PBSP_IDLE;
			addr_r <= `PBSP_ADDR_ZERO;
			cnt_r <= `PBSP_CNT_ZERO;
			wmask_r <= `PBSP_NO_LANES;
			waddr_r <= `PBSP_ADDR_ZERO;
			wword_r <= `PBSP_WORD_ZERO;
			rdv_r <= 1'b0;
			outv_r <= 1'b0;
			dq_r <= `PBSP_WORD_ZERO;
		end else begin
			state_r <= state_nxt;
			addr_r <= addr_nxt;
			cnt_r <= cnt_nxt;
			wmask_r <= wmask_nxt;
			waddr_r <= waddr_nxt;
			wword_r <= wword_nxt;
			rdv_r <= rdv_nxt;
			outv_r <= outv_nxt;
			dq_r <= dq_nxt;
		end
	end

	// ****************************************
	// array and pins
	// ****************************************
	// write lands one edge after capture; write-through hides the gap
	pbsp_mem u_mem (
		.i_mclk(i_mclk),
		.i_rd_addr(acc_addr),
		.o_rd_word(mem_rd),
		.i_wr_mask(wmask_r),
		.i_wr_addr(waddr_r),
		.i_wr_word(wword_r)
	);

	assign o_dq = dq_r.data;
	assign o_parity_io = dq_r.parity;
	// output enable acts without the clock [RULE_09] [RULE_10] [RULE_14]
	assign o_dq_oe = outv_r && !i_output_enable_n && !i_sleep_request;

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_rst_n);

	chk_addr_capture: assert property ( // [RULE_01]
		start |=> (addr_r == $past(i_addr)) && (state_r == PBSP_BURST))
		else $error("address not captured on qualified strobe");
	chk_burst_seed: assert property ( // [RULE_02]
		start |=> (cnt_r == `PBSP_CNT_ZERO))
		else $error("burst counter not seeded");
	chk_burst_step: assert property ( // [RULE_06]
		(state_r == PBSP_BURST && !any_seen && !i_sleep_request &&
		!i_burst_advance_n) |=> (cnt_r == $past(cnt_r) + `PBSP_CNT_STEP))
		else $error("burst counter did not step");
	chk_burst_hold: assert property ( // [RULE_06]
		(!any_seen && i_burst_advance_n) |=> $stable(cnt_r))
		else $error("burst counter moved without advance");
	chk_select_need: assert property ( // [RULE_07]
		(i_chip_sel_one_n || !i_chip_sel_two || i_chip_sel_three_n)
		|=> (state_r == PBSP_IDLE) || $stable(addr_r))
		else $error("access started while not selected");
	chk_proc_gate: assert property ( // [RULE_08]
		(!i_proc_addr_strobe_n && i_chip_sel_one_n && i_ctrl_addr_strobe_n)
		|=> $stable(addr_r) && (outv_r == $past(rdv_r)))
		else $error("processor strobe acted with select one high");
	chk_oe_async: assert property ( // [RULE_09]
		o_dq_oe |-> (!i_output_enable_n && outv_r))
		else $error("pins driven without output enable");
	chk_first_mask: assert property ( // [RULE_10]
		(state_r == PBSP_IDLE && start) |=> !o_dq_oe)
		else $error("pins driven in first read clock");
	chk_lanes_all: assert property ( // [RULE_04]
		(state_r == PBSP_BURST && !any_seen && !i_sleep_request &&
		!i_wr_ctrl.all_lanes_write_n) |=> (wmask_r == `PBSP_ALL_LANES))
		else $error("global write did not select all lanes");
	chk_lanes_sel: assert property ( // [RULE_03]
		(((ctrl_seen && selected) || (state_r == PBSP_BURST &&
		!any_seen && !i_sleep_request)) &&
		i_wr_ctrl.all_lanes_write_n && !i_wr_ctrl.lane_write_enable_n)
		|=> (wmask_r == ~$past(i_wr_ctrl.byte_lane_write_sel_n)))
		else $error("lane selects not applied");
	chk_proc_first: assert property ( // [RULE_19]
		(start && proc_seen) |=> (wmask_r == `PBSP_NO_LANES) && rdv_r)
		else $error("write controls used on processor start");
	chk_wdata_reg: assert property ( // [RULE_15]
		do_write |=> (wword_r == $past({i_parity_io, i_dq})))
		else $error("write data not captured");
	chk_read_pipe: assert property ( // [RULE_16]
		(rdv_r && !any_seen) |=> outv_r && (dq_r == $past(mem_rd)))
		else $error("read data not presented next clock");
	chk_sleep_quiet: assert property ( // [RULE_14]
		i_sleep_request |=> $stable(addr_r) && (wmask_r == `PBSP_NO_LANES))
		else $error("activity during sleep");

endmodule
